// *** src/bwsc_cfg.svh ***
// constants of the bus wake and sleep controller
// assumes a 250 MHz clock; included by the recogniser and top design files
`ifndef BWSC_CFG_SVH
`define BWSC_CFG_SVH
`define BWSC_CLK_MHZ        250
`define BWSC_PHASE_MIN_US   4
`define BWSC_PHASE_MAX_US   40
// both limits are plain products of us and MHz, with no rounding; both exact at 250 MHz
`define BWSC_PHASE_MIN_CYC  (`BWSC_PHASE_MIN_US * `BWSC_CLK_MHZ)
`define BWSC_PHASE_MAX_CYC  (`BWSC_PHASE_MAX_US * `BWSC_CLK_MHZ)
`define BWSC_CNT_W          14
`define BWSC_IDLE_W         24
`endif

// *** src/bwsc_pkg.sv ***
// types of the bus wake and sleep controller
// assumes bwsc_cfg.svh alongside
`default_nettype none
package bwsc_pkg;
  typedef enum logic [1:0] {
    BWSC_OFF     = 2'b00,
    BWSC_STANDBY = 2'b01,
    BWSC_ON      = 2'b10
  } bwsc_power_type;
  typedef enum logic [1:0] {
    BWSC_P_IDLE = 2'b00,
    BWSC_P_LOW  = 2'b01,
    BWSC_P_HIGH = 2'b10
  } bwsc_pat_type;
endpackage
`default_nettype wire

// *** src/bwsc_pattern.sv ***
// wake-up symbol recogniser for one bus channel
// assumes rx_low is synchronous, high when the channel shows a low (data 0) phase
`include "bwsc_cfg.svh"
`default_nettype none
module bwsc_pattern (
  // clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // channel
  input  wire logic rx_low,
  // result
  output logic      found
);
  import bwsc_pkg::*;
  localparam logic [`BWSC_CNT_W-1:0] MIN_C = `BWSC_CNT_W'(`BWSC_PHASE_MIN_CYC);
  localparam logic [`BWSC_CNT_W-1:0] MAX_C = `BWSC_CNT_W'(`BWSC_PHASE_MAX_CYC);
  bwsc_pat_type           st_reg, st_next;
  logic [`BWSC_CNT_W-1:0] cnt_reg, cnt_next;
  logic                   found_reg, found_next;

  // phase timing: low 4..40 us then high of at least 4 us; high ends on next low or on reaching min
  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    found_next = 1'b0;
    case (st_reg)
      BWSC_P_IDLE: begin
        cnt_next = '0;
        if (rx_low) begin
          st_next  = BWSC_P_LOW;
          cnt_next = `BWSC_CNT_W'(1);
        end
      end
      BWSC_P_LOW: begin
        if (rx_low) begin
          // saturate one past max: an overlong low must not re-arm while it lasts
          if (cnt_reg <= MAX_C) begin
            cnt_next = cnt_reg + `BWSC_CNT_W'(1);
          end
        end else if (cnt_reg >= MIN_C && cnt_reg <= MAX_C) begin
          st_next  = BWSC_P_HIGH;
          cnt_next = `BWSC_CNT_W'(1);
        end else begin
          st_next = BWSC_P_IDLE; // too short or too long, rejected
        end
      end
      BWSC_P_HIGH: begin
        // idle counts as high, so reaching min already qualifies
        if (!rx_low && cnt_reg + `BWSC_CNT_W'(1) == MIN_C) begin
          found_next = 1'b1;
          st_next    = BWSC_P_IDLE;
        end else if (rx_low) begin
          st_next  = BWSC_P_LOW; // short high: restart on the new low
          cnt_next = `BWSC_CNT_W'(1);
        end else begin
          cnt_next = cnt_reg + `BWSC_CNT_W'(1);
        end
      end
      default: begin
        st_next  = BWSC_P_IDLE;
        cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_reg    <= BWSC_P_IDLE;
      cnt_reg   <= '0;
      found_reg <= 1'b0;
    end else begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      found_reg <= found_next;
    end
  end
  assign found = found_reg;

  // a short low never yields a symbol
  short_low_a: assert property (@(posedge clock) disable iff (reset)
    (st_reg == BWSC_P_LOW && !rx_low && cnt_reg < MIN_C) |=> st_reg == BWSC_P_IDLE)
    else $error("short low phase accepted");
  // an overlong low never yields a symbol
  long_low_a: assert property (@(posedge clock) disable iff (reset)
    (st_reg == BWSC_P_LOW && !rx_low && cnt_reg > MAX_C) |=> st_reg == BWSC_P_IDLE)
    else $error("long low phase accepted");
endmodule
`default_nettype wire

// *** src/bwsc_top.sv ***
// power-state controller watching both bus channels for wake and sleep
// assumes synchronous inputs; traffic flags come from the bus receivers
`include "bwsc_cfg.svh"
`default_nettype none
module bwsc_top (
  // clock and reset
  input  wire logic                     CLOCK,
  input  wire logic                     RESET,
  // bus channels
  input  wire logic                     CHA_TRAFFIC,
  input  wire logic                     CHB_TRAFFIC,
  input  wire logic                     CHA_RX_LOW,
  input  wire logic                     CHB_RX_LOW,
  // host configuration
  input  wire logic                     RESET_TO_STANDBY,
  input  wire logic                     POWER_ENABLE,
  input  wire logic                     WAKE_ON_TRAFFIC_EN,
  input  wire logic                     WAKE_ON_SYMBOL_EN,
  input  wire logic                     SLEEP_EN,
  input  wire logic [`BWSC_IDLE_W-1:0]  IDLE_TIMEOUT,
  // status
  output bwsc_pkg::bwsc_power_type      POWER_STATE,
  output logic                          SLEEP,
  output logic                          WAKE_EVENT
);
  import bwsc_pkg::*;
  logic                    sym_a, sym_b, traffic;
  bwsc_power_type          st_reg, st_next;
  logic [`BWSC_IDLE_W-1:0] idle_reg, idle_next;
  logic                    sleep_reg, sleep_next;
  logic                    wake_reg, wake_next;
  logic                    strap_reg;
  logic                    init_reg;

  // one recogniser per channel
  bwsc_pattern u_pat_a (
    .clock  (CLOCK),
    .reset  (RESET),
    .rx_low (CHA_RX_LOW),
    .found  (sym_a)
  );
  bwsc_pattern u_pat_b (
    .clock  (CLOCK),
    .reset  (RESET),
    .rx_low (CHB_RX_LOW),
    .found  (sym_b)
  );
  assign traffic = CHA_TRAFFIC | CHB_TRAFFIC;

  // idle counter and state machine
  always_comb begin
    idle_next  = idle_reg;
    sleep_next = sleep_reg;
    wake_next  = 1'b0;
    st_next    = st_reg;
    // idle timer restarts on any traffic
    if (traffic) begin
      idle_next  = '0;
      sleep_next = 1'b0;
    end else if (idle_reg >= IDLE_TIMEOUT) begin
      sleep_next = SLEEP_EN;
    end else begin
      idle_next = idle_reg + `BWSC_IDLE_W'(1);
    end
    case (st_reg)
      BWSC_OFF: begin
        if (init_reg && strap_reg) begin
          st_next = BWSC_STANDBY;
        end else if (POWER_ENABLE) begin
          st_next = BWSC_STANDBY;
        end
      end
      BWSC_STANDBY: begin
        if (!POWER_ENABLE) begin
          st_next = BWSC_OFF;
        end else if ((WAKE_ON_TRAFFIC_EN && traffic)
                  || (WAKE_ON_SYMBOL_EN && (sym_a || sym_b))) begin
          st_next   = BWSC_ON;
          wake_next = 1'b1;
        end
      end
      BWSC_ON: begin
        if (!POWER_ENABLE) begin
          st_next = BWSC_OFF;
        end else if (sleep_reg) begin
          st_next = BWSC_STANDBY; // sleep drops back to standby
        end
      end
      default: st_next = BWSC_OFF;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      st_reg    <= BWSC_OFF;
      idle_reg  <= '0;
      sleep_reg <= 1'b0;
      wake_reg  <= 1'b0;
      init_reg  <= 1'b1;
    end else begin
      st_reg    <= st_next;
      idle_reg  <= idle_next;
      sleep_reg <= sleep_next;
      wake_reg  <= wake_next;
      init_reg  <= 1'b0;
    end
  end

  // strap captured by the clock while reset is held, not by the reset itself
  always_ff @(posedge CLOCK) begin
    strap_reg <= RESET ? RESET_TO_STANDBY : strap_reg;
  end

  assign POWER_STATE = st_reg;
  assign SLEEP       = sleep_reg;
  assign WAKE_EVENT  = wake_reg;

  legal_state_a: assert property (@(posedge CLOCK) disable iff (RESET)
    st_reg inside {BWSC_OFF, BWSC_STANDBY, BWSC_ON})
    else $error("illegal power state");
  traffic_wake_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (st_reg == BWSC_STANDBY && POWER_ENABLE && WAKE_ON_TRAFFIC_EN && traffic)
    |=> st_reg == BWSC_ON && WAKE_EVENT)
    else $error("traffic did not wake");
  symbol_wake_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (st_reg == BWSC_STANDBY && POWER_ENABLE && WAKE_ON_SYMBOL_EN && (sym_a || sym_b))
    |=> st_reg == BWSC_ON)
    else $error("wake symbol ignored");
  no_wake_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (st_reg == BWSC_STANDBY && !WAKE_ON_TRAFFIC_EN && !WAKE_ON_SYMBOL_EN)
    |=> st_reg != BWSC_ON)
    else $error("woke with wake disabled");
  sleep_clear_a: assert property (@(posedge CLOCK) disable iff (RESET)
    traffic |=> !SLEEP && idle_reg == '0)
    else $error("sleep held during traffic");
  sleep_set_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (!traffic && SLEEP_EN && idle_reg >= IDLE_TIMEOUT) |=> SLEEP)
    else $error("sleep not set at timeout");
  sleep_off_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (!SLEEP_EN && !SLEEP) |=> !SLEEP)
    else $error("sleep with sleep disabled");
  on_to_standby_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (st_reg == BWSC_ON && POWER_ENABLE && SLEEP) |=> st_reg == BWSC_STANDBY)
    else $error("sleep did not leave on");
  power_off_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (st_reg != BWSC_OFF && !POWER_ENABLE) |=> st_reg == BWSC_OFF)
    else $error("power enable low did not force off");
endmodule
`default_nettype wire

// *** tb/bwsc_bus_node.sv ***
// far-side bus nodes: traffic bursts and wake symbols on both channels
// assumes the bench clock; lines change by nonblocking just after edges
`default_nettype none
module bwsc_bus_node (
  // clock
  input  wire logic clock,
  // channel flags, silent and idle outside frames
  output logic      traffic_a,
  output logic      traffic_b,
  output logic      rx_low_a,
  output logic      rx_low_b
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {traffic_a, traffic_b, rx_low_a, rx_low_b} = 4'h0;
  // traffic on one channel for n cycles, then silence
  task automatic burst(input logic ch, input int n);
    @(posedge clock);
    if (ch) traffic_b <= 1'b1;
    else traffic_a <= 1'b1;
    repeat (n) @(posedge clock);
    {traffic_a, traffic_b} <= 2'h0;
  endtask
  // low phase of lo cycles, then idle, which counts as the high phase
  task automatic symbol(input logic ch, input int lo, hi);
    @(posedge clock);
    if (ch) rx_low_b <= 1'b1;
    else rx_low_a <= 1'b1;
    repeat (lo) @(posedge clock);
    {rx_low_a, rx_low_b} <= 2'h0;
    repeat (hi) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// *** tb/bwsc_top_test.sv ***
// bench for the bus wake and sleep controller
// assumes bwsc_bus_node as the other nodes; idle timeout fixed at 20
`default_nettype none
module bwsc_top_test;
  import bwsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic           clock = 1'b0, reset = 1'b1, strap = 1'b1, pwr_en = 1'b1;
  logic           tr_en = 1'b1, sym_en = 1'b1, slp_en = 1'b1;
  logic           cha_t, chb_t, cha_l, chb_l, sleep, wake;
  bwsc_power_type state;
  int             num_errors = 0, n_compared = 0, cycles = 0;
  // 250 MHz clock
  always #2 clock = ~clock;
  bwsc_bus_node u_node (.clock(clock), .traffic_a(cha_t), .traffic_b(chb_t),
    .rx_low_a(cha_l), .rx_low_b(chb_l));
  bwsc_top u_dut (.CLOCK(clock), .RESET(reset), .CHA_TRAFFIC(cha_t), .CHB_TRAFFIC(chb_t),
    .CHA_RX_LOW(cha_l), .CHB_RX_LOW(chb_l), .RESET_TO_STANDBY(strap),
    .POWER_ENABLE(pwr_en), .WAKE_ON_TRAFFIC_EN(tr_en), .WAKE_ON_SYMBOL_EN(sym_en),
    .SLEEP_EN(slp_en), .IDLE_TIMEOUT(24'h000014), .POWER_STATE(state),
    .SLEEP(sleep), .WAKE_EVENT(wake));
  task automatic check(input logic [3:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d, mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // a pulse caught once only; the state is judged in the pulse cycle
  task automatic wait_wake(input int n, input logic exp);
    logic got;
    got = 1'b0;
    repeat (n) begin
      @(posedge clock);
      #1;
      if (wake === 1'b1 && got) begin
        check(wake, 1'b0);
      end
      if (wake === 1'b1 && !got) begin
        got = 1'b1;
        check(state, BWSC_ON);
      end
    end
    check(got, exp);
  endtask
  // silence after traffic: no early sleep, then back to standby
  task automatic t_sleep;
    int n;
    n = 0;
    while (sleep !== 1'b1 && n < 100) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(n == 21, 1'b1);
    check(sleep, 1'b1);
    @(posedge clock);
    #1;
    check(state, BWSC_STANDBY);
  endtask
  task automatic t_reset;
    repeat (5) @(posedge clock);
    #1;
    check(state, BWSC_OFF);
    check(sleep, 1'b0);
    @(posedge clock) reset <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check(state, BWSC_STANDBY);
    $display("reset test done");
  endtask
  // traffic wakes from either channel, but not while disabled
  task automatic t_traffic;
    for (int ch = 0; ch < 3; ch++) begin
      @(posedge clock) tr_en <= (ch != 2);
      fork
        u_node.burst(ch[0], 40);
        wait_wake(20, ch != 2);
      join
      if (ch != 2) t_sleep();
    end
    @(posedge clock) tr_en <= 1'b1;
    $display("traffic test done");
  endtask
  // sleep held off while disabled, taken once enabled
  task automatic t_sleep_en;
    @(posedge clock) slp_en <= 1'b0;
    fork
      u_node.burst(1'b0, 10);
      wait_wake(20, 1'b1);
    join
    repeat (60) @(posedge clock);
    #1;
    check(state, BWSC_ON);
    check(sleep, 1'b0);
    @(posedge clock) slp_en <= 1'b1;
    repeat (40) @(posedge clock);
    #1;
    check(state, BWSC_STANDBY);
    $display("sleep enable test done");
  endtask
  // low phase at and beyond both limits, channels alternating A and B, once with all wake off
  task automatic t_symbol;
    int lo_tab[7] = '{1000, 990, 10000, 10010, 1200, 1000, 12000};
    bit exp_tab[7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 7; i++) begin
      @(posedge clock) sym_en <= (i != 4);
      tr_en <= (i != 4);
      fork
        u_node.symbol(i[0], lo_tab[i], 1100);
        wait_wake(lo_tab[i] + 1100, exp_tab[i]);
      join
      for (int k = 0; k < 100 && state !== BWSC_STANDBY; k++) begin
        @(posedge clock);
        #1;
      end
      check(state, BWSC_STANDBY);
    end
    $display("symbol test done");
  endtask
  // mid-run reset without strap; power enable moves between off and the rest
  task automatic t_power;
    @(posedge clock) reset <= 1'b1;
    strap <= 1'b0;
    pwr_en <= 1'b0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check(state, BWSC_OFF);
    check(sleep, 1'b0);
    @(posedge clock) pwr_en <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check(state, BWSC_STANDBY);
    fork
      u_node.burst(1'b0, 10);
      wait_wake(20, 1'b1);
    join
    @(posedge clock) pwr_en <= 1'b0;
    @(posedge clock);
    #1;
    check(state, BWSC_OFF);
    fork
      u_node.burst(1'b1, 10);
      wait_wake(20, 1'b0);
    join
    check(state, BWSC_OFF);
    @(posedge clock) pwr_en <= 1'b1;
    strap <= 1'b1;
    @(posedge clock);
    #1;
    check(state, BWSC_STANDBY);
    @(posedge clock) pwr_en <= 1'b0;
    @(posedge clock);
    #1;
    check(state, BWSC_OFF);
    @(posedge clock) pwr_en <= 1'b1;
    $display("power test done");
  endtask
  // cut a hang short
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    t_reset();
    t_traffic();
    t_sleep_en();
    t_symbol();
    t_power();
    print_verdict();
  end
endmodule
`default_nettype wire
